/* lnuf_frame_handler.sv */
// LIN/UART frame handler and its transmit FIFO.
// Assumes a transceiver on LIN_RXD_I/LIN_TXD_O, all inputs synchronous.
// Operation
// RULE_01: Frame is header then response.
// RULE_02: Header is break, sync, protected identifier.
// RULE_03: Response is data bytes then checksum.
// RULE_04: Bytes are async characters, LSB first.
// RULE_05: Only the assigned slave drives response.
// RULE_06: Receiver checks checksum before accepting data.
// RULE_07: LIN bit rate at most 20 kbit/s.
// RULE_08: Diagnostics only in two reserved identifiers.
// RULE_09: Frame time-out detected in hardware.
// RULE_10: Older-revision nodes get no enhanced features.
// RULE_11: UART transmit and receive run full duplex.
// RULE_12: UART: 8 data, optional parity, 1 stop.
// RULE_13: UART flags overrun and framing errors.
// RULE_14: Break is 13 dominant bit times.
// RULE_15: Sync field is character 0x55.
// RULE_16: Identifiers 60 to 63 raise hardware flags.
// RULE_17: Sync edges resynchronise bit timing.
// RULE_18: Checksum is inverted sum with carry.
`timescale 1ns/1ps
`include "lnuf_regs.svh"

// Transmit FIFO with registered ready toward the filling side.
module lnuf_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(D);
  // Storage, pointers, fill level and registered ready.
  typedef struct packed {
    logic [D-1:0][W-1:0] mem; logic [AW-1:0] wp; logic [AW-1:0] rp;
    logic [AW:0] cnt; logic rdy;
  } lnuf_fifo_s;
  lnuf_fifo_s q, n;
  logic push, pop;
  assign in_ready_o  = q.rdy;
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o  = q.mem[q.rp];
  // Next state: write on push, advance read on pop.
  always_comb begin
    n    = q;
    push = in_valid_i && q.rdy;
    pop  = out_ready_i && (q.cnt != '0);
    if (push) begin
      n.mem[q.wp] = in_data_i;
      n.wp        = q.wp + 1'b1;
    end
    if (pop) begin
      n.rp = q.rp + 1'b1;
    end
    n.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    n.rdy = (n.cnt != (AW+1)'(D));
  end
  // State register with synchronous reset.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q     <= '0;
      q.rdy <= 1'b1;
    end else begin
      q <= n;
    end
  end
endmodule

// Frame handler top: header, response and UART character engines.
module lnuf_frame_handler (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic        LIN_RXD_I,
  output logic             LIN_TXD_O,
  input  wire logic        UART_MODE_I,
  input  wire logic [1:0]  PARITY_I,
  input  wire logic        LIN13_I,
  input  wire logic        HDR_START_I,
  input  wire logic [5:0]  HDR_ID_I,
  input  wire logic        RESP_TX_I,
  input  wire logic        RESP_RX_I,
  input  wire logic [3:0]  RESP_LEN_I,
  input  wire logic [7:0]  TX_DATA_I,
  input  wire logic        TX_VALID_I,
  output logic             TX_READY_O,
  output logic [7:0]       RX_DATA_O,
  output logic             RX_VALID_O,
  input  wire logic        RX_READY_I,
  output logic             ID_OK_O,
  output logic [5:0]       ID_O,
  output logic             ID_SPECIAL_O,
  output logic             ID_DIAG_O,
  output logic [63:0]      RESP_DATA_O,
  output logic             RESP_OK_O,
  output logic             RESP_SENT_O,
  output logic             CSUM_ERR_O,
  output logic             PARITY_ERR_O,
  output logic             FRAME_ERR_O,
  output logic             OVERRUN_O,
  output logic             TIMEOUT_O
);
  import lnuf_pkg::*;

  lnuf_top_s q, n;            // Registered state and its next value.
  logic [7:0] f_data;         // Head byte of the transmit FIFO.
  logic       f_valid;        // FIFO holds a byte.
  logic       pop;            // Take the head byte this cycle.
  logic       tdone;          // Current character ends this cycle.
  logic       cdone;          // A received character completes.
  logic [10:0] nsh;           // Receive shift with the new sample.
  logic [7:0] cdata;          // Received data byte.
  logic       cstop;          // Received stop bit level.
  logic       cperr;          // Received parity mismatch.
  logic [7:0] init;           // Checksum seed for this frame.

  // Protected identifier: two parity bits above the 6-bit identifier.
  function automatic logic [7:0] pid(input logic [5:0] i);
    pid = {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
  endfunction
  // Sum with end-around carry.
  function automatic logic [7:0] csum_add(input logic [7:0] a,
                                          input logic [7:0] b);
    logic [8:0] s;
    s        = {1'b0, a} + {1'b0, b};
    csum_add = s[7:0] + {7'h00, s[8]};
  endfunction
  // Parity bit for a byte under the chosen mode.
  function automatic logic par_bit(input logic [7:0] d,
                                   input logic [1:0] m);
    par_bit = (m == `LNUF_PAR_ODD) ? ~^d : ^d;
  endfunction
  // Character bits, start bit at bit 0, then data LSB first.
  function automatic logic [10:0] chr(input logic [7:0] d,
                                      input logic [1:0] m);
    if (m == `LNUF_PAR_NONE) begin
      chr = {2'b11, d, 1'b0};
    end else begin
      chr = {1'b1, par_bit(d, m), d, 1'b0};
    end
  endfunction
  // Character length in bits.
  function automatic logic [3:0] chr_len(input logic [1:0] m);
    chr_len = (m == `LNUF_PAR_NONE) ? `LNUF_CHR_NP : `LNUF_CHR_P;
  endfunction
  // Longest frame in bit times for a response length.
  function automatic logic [8:0] frame_max(input logic [3:0] l);
    frame_max = 9'((`LNUF_HDR_BITS + `LNUF_BYTE_BITS * (int'(l) + 1))
                   * `LNUF_TOL_NUM / `LNUF_TOL_DEN);
  endfunction

  lnuf_fifo #(.W(8), .D(8)) u_fifo (
    .clk_i       (CORE_CLK_I),
    .rst_n_i     (RESETN_I),
    .in_data_i   (TX_DATA_I),
    .in_valid_i  (TX_VALID_I),
    .in_ready_o  (TX_READY_O),
    .out_data_o  (f_data),
    .out_valid_o (f_valid),
    .out_ready_i (pop)
  );

  assign LIN_TXD_O    = q.line;
  assign RX_DATA_O    = q.rdata;
  assign RX_VALID_O   = q.rvalid;
  assign ID_OK_O      = q.idok;
  assign ID_O         = q.id;
  assign ID_SPECIAL_O = q.idsp;
  assign ID_DIAG_O    = q.iddg;
  assign RESP_DATA_O  = q.resp;
  assign RESP_OK_O    = q.rok;
  assign RESP_SENT_O  = q.tok;
  assign CSUM_ERR_O   = q.cerr;
  assign PARITY_ERR_O = q.perr;
  assign FRAME_ERR_O  = q.ferr;
  assign OVERRUN_O    = q.ovr;
  assign TIMEOUT_O    = q.tmo;

  // Next state of both engines, the frame sequencer and the time-out.
  always_comb begin
    n = q;
    pop = 1'b0;
    cdone = 1'b0;
    nsh = {LIN_RXD_I, q.rsh[10:1]};
    cdata = 8'h00;
    cstop = 1'b1;
    cperr = 1'b0;
    init = 8'h00;
    {n.idok, n.rok, n.tok, n.cerr, n.perr, n.ferr, n.ovr, n.tmo} = '0;
    n.rxp = LIN_RXD_I;
    if (RX_READY_I) begin
      n.rvalid = 1'b0;
    end
    // Transmit bit timer at the fixed bit rate.
    tdone = (q.tbits == 4'h1) && (q.tcnt == `LNUF_BIT_CYC - 10'h001);
    if (q.tbits != 4'h0) begin
      if (q.tcnt == `LNUF_BIT_CYC - 10'h001) begin  // see RULE_07
        n.tcnt  = 10'h000;
        n.tbits = q.tbits - 4'h1;
        n.tsh   = {1'b1, q.tsh[10:1]};  // see RULE_04
      end else begin
        n.tcnt = q.tcnt + 10'h001;
      end
    end
    // Transmit sequencer.
    case (q.tph)
      T_IDLE: begin
        if (UART_MODE_I) begin
          if (q.tbits == 4'h0 && f_valid) begin  // see RULE_11
            pop     = 1'b1;
            n.tsh   = chr(f_data, PARITY_I);  // see RULE_12
            n.tbits = chr_len(PARITY_I);
          end
        end else if (HDR_START_I) begin  // see RULE_01
          n.tph   = T_BRK;
          n.hid   = HDR_ID_I;
          n.tbits = `LNUF_BRK_LEN;  // see RULE_14
          n.tcnt  = 10'h000;
        end
      end
      T_BRK: begin
        if (tdone) begin
          n.tph   = T_SYNC;
          n.tsh   = chr(`LNUF_SYNC, `LNUF_PAR_NONE);  // see RULE_15
          n.tbits = `LNUF_CHR_NP;
        end
      end
      T_SYNC: begin
        if (tdone) begin
          n.tph   = T_PID;
          n.tsh   = chr(pid(q.hid), `LNUF_PAR_NONE);  // see RULE_02
          n.tbits = `LNUF_CHR_NP;
        end
      end
      T_PID: begin
        if (tdone) begin
          n.tph = T_IDLE;
        end
      end
      T_DATA: begin
        if (q.tbits == 4'h0) begin
          if (q.tidx == q.len) begin
            n.tph   = T_CSUM;
            n.tsh   = chr(~q.tsum, `LNUF_PAR_NONE);  // see RULE_03
            n.tbits = `LNUF_CHR_NP;
          end else if (f_valid) begin
            pop     = 1'b1;
            n.tsh   = chr(f_data, `LNUF_PAR_NONE);
            n.tbits = `LNUF_CHR_NP;
            n.tsum  = csum_add(q.tsum, f_data);  // see RULE_18
            n.tidx  = q.tidx + 4'h1;
          end
        end
      end
      default: begin
        if (tdone) begin
          n.tph     = T_IDLE;
          n.tok     = 1'b1;
          n.tx_pend = 1'b0;
          n.fr_on   = q.rx_pend;
        end
      end
    endcase
    // Response commands are latched until the identifier arrives.
    if (!UART_MODE_I && RESP_TX_I) begin
      n.tx_pend = 1'b1;
      n.len     = RESP_LEN_I;
    end
    if (!UART_MODE_I && RESP_RX_I) begin
      n.rx_pend = 1'b1;
      n.len     = RESP_LEN_I;
    end
    // Receive character engine; start search is held off during sync.
    if (!q.rbusy) begin
      if (q.rxp && !LIN_RXD_I && q.rst != R_SYNC) begin
        n.rbusy = 1'b1;
        n.rcnt  = {1'b0, q.blen[9:1]};
        n.rbit  = 4'h0;
      end
    end else if (q.rcnt != 10'h000) begin
      n.rcnt = q.rcnt - 10'h001;
    end else begin
      n.rcnt = q.blen - 10'h001;
      n.rsh  = nsh;
      n.rbit = q.rbit + 4'h1;
      if (q.rbit == 4'h0 && LIN_RXD_I) begin
        n.rbusy = 1'b0;
      end else if (q.rbit == (UART_MODE_I ? chr_len(PARITY_I)
                                          : `LNUF_CHR_NP) - 4'h1) begin
        n.rbusy = 1'b0;
        cdone   = 1'b1;
      end
    end
    // Field extraction; the stop bit is the newest sample.
    cstop = LIN_RXD_I;
    if (UART_MODE_I && PARITY_I != `LNUF_PAR_NONE) begin
      cdata = nsh[8:1];
      cperr = (nsh[9] != par_bit(nsh[8:1], PARITY_I));
    end else begin
      cdata = nsh[9:2];
    end
    // UART receive: one holding byte, overrun when it is not taken.
    if (UART_MODE_I) begin
      if (cdone) begin
        n.ovr    = q.rvalid && !RX_READY_I;  // see RULE_13
        n.ferr   = !cstop;  // see RULE_13
        n.perr   = cperr;
        n.rdata  = cdata;
        n.rvalid = 1'b1;
      end
    end else begin
      init = (LIN13_I || cdata[5:0] == `LNUF_ID_DIAG0 ||  // see RULE_10
              cdata[5:0] == `LNUF_ID_DIAG1) ? 8'h00 : pid(cdata[5:0]);
      // A break is accepted in any phase but R_SYNC, where no character starts.
      if (cdone && cdata == 8'h00 && !cstop) begin
        n.rst   = R_SYNC;
        n.edges = 3'h0;
        n.meas  = 13'h0000;
        n.fr_on = 1'b1;
        n.fcyc  = 10'h000;
        n.fbits = 9'h000;
      end else begin
        case (q.rst)
          R_SYNC: begin
            if (q.edges != 3'h0) begin
              n.meas = q.meas + 13'h0001;
            end
            if (q.rxp && !LIN_RXD_I) begin  // see RULE_17
              n.edges = q.edges + 3'h1;
              if (q.edges == `LNUF_SYNC_FALLS) begin
                n.blen = q.meas[12:3];
                n.rst  = R_PID;
              end
            end
          end
          R_PID: begin
            if (cdone) begin
              n.rst = R_BRK;
              if (pid(cdata[5:0]) != cdata || !cstop) begin
                n.perr  = 1'b1;
                n.fr_on = 1'b0;
              end else begin
                n.idok  = 1'b1;
                n.id    = cdata[5:0];
                n.idsp  = cdata[5:0] >= `LNUF_ID_SPEC;  // see RULE_16
                n.iddg  = cdata[5:0] == `LNUF_ID_DIAG0 ||
                          cdata[5:0] == `LNUF_ID_DIAG1;  // see RULE_08
                n.fr_on = q.tx_pend || q.rx_pend;
                n.tidx  = 4'h0;
                n.ridx  = 4'h0;
                n.tsum  = init;
                n.rsum  = init;
                if (q.tx_pend) begin  // see RULE_05
                  n.tph = T_DATA;
                end
                if (q.rx_pend) begin
                  n.rst = R_DATA;
                end
              end
            end
          end
          R_DATA: begin
            if (cdone && !cstop) begin
              n.ferr    = 1'b1;
              n.rst     = R_BRK;
              n.rx_pend = 1'b0;
              n.fr_on   = q.tx_pend;
            end else if (cdone && q.ridx == q.len) begin
              n.rst     = R_BRK;
              n.rx_pend = 1'b0;
              n.fr_on   = q.tx_pend;
              if (cdata == ~q.rsum) begin  // see RULE_06
                n.resp = q.rbuf;
                n.rok  = 1'b1;
              end else begin
                n.cerr = 1'b1;
              end
            end else if (cdone) begin
              n.rbuf[{q.ridx[2:0], 3'b000} +: 8] = cdata;
              n.rsum = csum_add(q.rsum, cdata);  // see RULE_18
              n.ridx = q.ridx + 4'h1;
            end
          end
          default: begin
          end
        endcase
      end
      // Frame time-out counted in bit times.
      if (q.fr_on) begin
        if (q.fcyc == `LNUF_BIT_CYC - 10'h001) begin
          n.fcyc  = 10'h000;
          n.fbits = q.fbits + 9'h001;
        end else begin
          n.fcyc = q.fcyc + 10'h001;
        end
        if ((q.tx_pend || q.rx_pend) &&
            q.fbits > frame_max(q.len)) begin  // see RULE_09
          n.tmo     = 1'b1;
          n.fr_on   = 1'b0;
          n.tx_pend = 1'b0;
          n.rx_pend = 1'b0;
          n.rst     = R_BRK;
          n.tph     = T_IDLE;
          n.tbits   = 4'h0;
        end
      end
    end
    // Line level: break low except delimiter, else the shifter.
    if (n.tbits == 4'h0) begin
      n.line = 1'b1;
    end else if (n.tph == T_BRK) begin
      n.line = (n.tbits == 4'h1);
    end else begin
      n.line = n.tsh[0];
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      q      <= '0;
      q.line <= 1'b1;
      q.rxp  <= 1'b1;
      q.blen <= `LNUF_BIT_CYC;
    end else begin
      q <= n;
    end
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);
  property p_brk_len;
    $rose(q.tph == T_BRK) |-> q.tbits == `LNUF_BRK_LEN && !LIN_TXD_O;
  endproperty
  a_brk_len: assert property (p_brk_len) else $error("bad break"); // RULE_14
  property p_sync;
    q.tph == T_BRK && tdone |=> q.tph == T_SYNC && q.tsh[8:1] == `LNUF_SYNC;
  endproperty
  a_sync: assert property (p_sync) else $error("bad sync"); // RULE_15
  property p_pid;
    q.tph == T_SYNC && tdone |=> q.tph == T_PID && q.tsh[8:1] == pid(q.hid);
  endproperty
  a_pid: assert property (p_pid) else $error("bad pid"); // RULE_02
  property p_lsb;
    q.tbits != 4'h0 && q.tph != T_BRK |-> LIN_TXD_O == q.tsh[0];
  endproperty
  a_lsb: assert property (p_lsb) else $error("bad bit order"); // RULE_04
  property p_silent;
    q.tph == T_IDLE && !UART_MODE_I |-> LIN_TXD_O;
  endproperty
  a_silent: assert property (p_silent) else $error("drove line"); // RULE_05
  property p_spec;
    ID_OK_O |-> ID_SPECIAL_O == (ID_O >= `LNUF_ID_SPEC);
  endproperty
  a_spec: assert property (p_spec) else $error("bad special flag"); // RULE_16
  property p_accept;
    RESP_OK_O |-> !CSUM_ERR_O && $past(q.rst) == R_DATA && q.rst == R_BRK;
  endproperty
  a_accept: assert property (p_accept) else $error("bad accept"); // RULE_06
  property p_tout;
    TIMEOUT_O |-> !q.fr_on && !q.tx_pend && !q.rx_pend;
  endproperty
  a_tout: assert property (p_tout) else $error("bad timeout"); // RULE_09
  property p_ferr;
    UART_MODE_I && cdone && !cstop |=> FRAME_ERR_O;
  endproperty
  a_ferr: assert property (p_ferr) else $error("missed ferr"); // RULE_13
  c_hdr: cover property (q.tph == T_PID && tdone);
  c_resp: cover property (RESP_OK_O);
  c_duplex: cover property (UART_MODE_I && q.rbusy && q.tbits != 4'h0);
endmodule

/* lnuf_frame_handler_bench.sv */
// Self-checking bench for the LIN/UART frame handler.
// Assumes the design files and the link partner are compiled first.
`timescale 1ns/1ps
`include "lnuf_regs.svh"
`define CHK(n, e, g) begin \
  checks_done++; \
  if ((e) !== (g)) begin \
    failures++; \
    $display("Error %s expected %h seen %h", n, e, g); \
  end \
end
module lnuf_frame_handler_bench;
  logic CORE_CLK_I, RESETN_I, LIN_RXD_I, LIN_TXD_O, UART_MODE_I;
  logic LIN13_I, HDR_START_I, RESP_TX_I, RESP_RX_I, TX_VALID_I;
  logic TX_READY_O, RX_VALID_O, RX_READY_I, ID_OK_O, ID_SPECIAL_O;
  logic ID_DIAG_O, RESP_OK_O, RESP_SENT_O, CSUM_ERR_O, PARITY_ERR_O;
  logic FRAME_ERR_O, OVERRUN_O, TIMEOUT_O, p_tx, p_stb, p_line;
  logic [1:0]  PARITY_I;
  logic [5:0]  HDR_ID_I, ID_O;
  logic [3:0]  RESP_LEN_I;
  logic [7:0]  TX_DATA_I, RX_DATA_O, p_byte;
  logic [63:0] RESP_DATA_O;
  logic [6:0]  evs;        // Event pulses, counted each cycle.
  int          ev[7];      // Pulse counts of the running test.
  int          failures, checks_done;
  logic [63:0] exp_q[4][$];  // Notes: wire, id, response, uart rx.

  // Wired-AND bus in LIN mode; separate lines in UART mode.
  assign LIN_RXD_I = UART_MODE_I ? p_tx : (LIN_TXD_O & p_tx);
  assign p_line = UART_MODE_I ? LIN_TXD_O : LIN_RXD_I;
  assign evs = {TIMEOUT_O, OVERRUN_O, FRAME_ERR_O, PARITY_ERR_O,
                CSUM_ERR_O, RESP_OK_O, RESP_SENT_O};

  lnuf_frame_handler dut (.*);
  lnuf_link_partner #(.BIT_CYC(int'(`LNUF_BIT_CYC))) p (
    .clk_i(CORE_CLK_I), .line_i(p_line), .tx_o(p_tx),
    .rx_byte_o(p_byte), .rx_stb_o(p_stb));

  // Free-running 10 MHz core clock.
  initial begin
    CORE_CLK_I = 1'b0;
    forever #50 CORE_CLK_I = ~CORE_CLK_I;
  end

  // Protected identifier: two parity bits above the identifier.
  function automatic logic [7:0] pid(input logic [5:0] i);
    return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
  endfunction

  // Eight-bit sum with the carry folded back in.
  function automatic logic [7:0] add_c(input logic [7:0] s,
                                       input logic [7:0] b);
    logic [8:0] t;
    t = s + b;
    return t[7:0] + t[8];
  endfunction

  // Takes the oldest note of one kind and compares it.
  task automatic pop_chk(input int k, input logic [63:0] g, input string n);
    logic [63:0] e;
    e = 'x;
    if (exp_q[k].size() > 0)
      e = exp_q[k].pop_front();
    `CHK(n, e, g)
  endtask

  // Watches results and pulses mid-cycle, where they are settled.
  always @(negedge CORE_CLK_I) begin
    for (int k = 0; k < 7; k++)
      ev[k] += int'(evs[k] === 1'b1);
    if (p_stb === 1'b1)
      pop_chk(0, {56'h0, p_byte}, "wire");
    if (ID_OK_O === 1'b1)
      pop_chk(1, {56'h0, ID_SPECIAL_O, ID_DIAG_O, ID_O}, "id");
    if (RESP_OK_O === 1'b1)
      pop_chk(2, {56'h0, RESP_DATA_O[7:0]}, "resp");
    if (RX_VALID_O === 1'b1 && RX_READY_I === 1'b1)
      pop_chk(3, {56'h0, RX_DATA_O}, "uart");
  end

  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (98000) @(posedge CORE_CLK_I);
    failures++;
    close_out();
  end

  // Holds reset for 16 cycles with the mode chosen.
  task automatic reset_dut(input logic m);
    RESETN_I = 1'b0;
    UART_MODE_I = m;
    repeat (16) @(posedge CORE_CLK_I);
    #1 RESETN_I = 1'b1;
    ev = '{default: 0};
  endtask

  // Writes one byte into the FIFO; valid stays up for the next byte.
  task automatic put(input logic [7:0] b);
    TX_DATA_I = b;
    TX_VALID_I = 1'b1;
    while (TX_READY_O !== 1'b1) begin
      @(posedge CORE_CLK_I);
      #1;
    end
    @(posedge CORE_CLK_I);
    #1;
  endtask

  // One-cycle command pulse: bits are rx arm, tx arm, header start.
  task automatic kick(input logic [2:0] m);
    @(posedge CORE_CLK_I);
    #1 {RESP_RX_I, RESP_TX_I, HDR_START_I} = m;
    @(posedge CORE_CLK_I);
    #1 {RESP_RX_I, RESP_TX_I, HDR_START_I} = 3'b000;
  endtask

  // Checks the pulse counts and that every note was used.
  task automatic end_test(input string n, input int e[7]);
    for (int k = 0; k < 7; k++)
      `CHK(n, e[k], ev[k])
    for (int k = 0; k < 4; k++)
      `CHK(n, 0, exp_q[k].size())
    $display("test %s done", n);
    ev = '{default: 0};
  endtask

  // Master frame, slave frame, then UART traffic.
  initial begin
    logic [7:0] d[8];
    logic [7:0] f[4];
    logic [7:0] s;
    logic [5:0] id;
    logic       lo;
    {PARITY_I, LIN13_I, HDR_ID_I, HDR_START_I} = '0;
    {RESP_TX_I, RESP_RX_I, RESP_LEN_I} = '0;
    {TX_DATA_I, TX_VALID_I, RX_READY_I} = 10'h001;
    void'($urandom(18196));
    reset_dut(1'b0);
    // Master: special identifier, FIFO filled to refusal, four bytes sent.
    id = 6'(60 + $urandom_range(0, 3));
    lo = 1'($urandom_range(0, 1));
    LIN13_I = lo;
    s = (lo || id < 6'h3E) ? 8'h00 : pid(id);
    exp_q[0] = '{64'd13, 64'h55, {56'h0, pid(id)}};
    exp_q[1].push_back({56'h0, 1'b1, id < 6'h3E, id});
    for (int i = 0; i < 8; i++) begin
      d[i] = 8'($urandom);
      if (i < 4) begin
        s = add_c(s, d[i]);
        exp_q[0].push_back({56'h0, d[i]});
      end
      put(d[i]);
    end
    TX_DATA_I = 8'hA5;
    @(posedge CORE_CLK_I);
    #1 `CHK("fifo ready", 1'b0, TX_READY_O)
    TX_VALID_I = 1'b0;
    exp_q[0].push_back({56'h0, ~s});
    RESP_LEN_I = 4'h4;
    HDR_ID_I = id;
    kick(3'b010);
    kick(3'b001);
    for (int i = 0; i < 50000 && ev[0] == 0; i++) begin
      @(posedge CORE_CLK_I);
      #1;
    end
    end_test("master", '{1, 0, 0, 0, 0, 0, 0});
    // Slave: ordinary identifier, enhanced checksum, one data byte.
    id = 6'($urandom_range(0, 59));
    d[0] = 8'($urandom);
    LIN13_I = 1'b0;
    f = '{8'h55, pid(id), d[0], ~add_c(pid(id), d[0])};
    exp_q[0].push_back(64'd13);
    foreach (f[i])
      exp_q[0].push_back({56'h0, f[i]});
    exp_q[1].push_back({58'h0, id});
    exp_q[2].push_back({56'h0, d[0]});
    RESP_LEN_I = 4'h1;
    kick(3'b100);
    p.send_break();
    foreach (f[i])
      p.send_char(f[i], `LNUF_PAR_NONE, 1'b0, 1'b1);
    end_test("slave", '{0, 1, 0, 0, 0, 0, 0});
    // UART: one odd-parity character each way at once.
    reset_dut(1'b1);
    PARITY_I = `LNUF_PAR_ODD;
    for (int i = 0; i < 5; i++)
      d[i] = 8'($urandom_range(1, 255));
    exp_q[0].push_back({56'h0, d[0]});
    exp_q[3].push_back({56'h0, d[1]});
    put(d[0]);
    TX_VALID_I = 1'b0;
    p.send_char(d[1], `LNUF_PAR_ODD, 1'b0, 1'b1);
    end_test("duplex", '{0, 0, 0, 0, 0, 0, 0});
    // UART: second byte lands while the first is unread.
    PARITY_I = `LNUF_PAR_NONE;
    RX_READY_I = 1'b0;
    exp_q[3].push_back({56'h0, d[3]});
    p.send_char(d[2], `LNUF_PAR_NONE, 1'b0, 1'b1);
    p.send_char(d[3], `LNUF_PAR_NONE, 1'b0, 1'b1);
    RX_READY_I = 1'b1;
    repeat (2) @(posedge CORE_CLK_I);
    #1 end_test("overrun", '{0, 0, 0, 0, 0, 1, 0});
    // UART: wrong even parity and a low stop bit in one character.
    PARITY_I = `LNUF_PAR_EVEN;
    RX_READY_I = 1'b0;
    p.send_char(d[4], `LNUF_PAR_EVEN, 1'b1, 1'b0);
    end_test("errors", '{0, 0, 0, 1, 1, 0, 0});
    close_out();
  end
endmodule

/* lnuf_link_partner.sv */
// Far-side LIN/UART node: sends characters and breaks, decodes the wire.
// Assumes the bench wires an open-drain bus with pull-up and calls the
// send tasks just after a rising clock edge.
`timescale 1ns/1ps
`include "lnuf_regs.svh"
module lnuf_link_partner #(
  parameter int BIT_CYC = 500
) (
  input  wire logic       clk_i,
  input  wire logic       line_i,
  output logic            tx_o,
  output logic [7:0]      rx_byte_o,
  output logic            rx_stb_o
);
  logic [7:0] b;  // Byte being decoded.
  int         n;  // Low cycles counted during a break.

  // The node starts recessive with a quiet decoder.
  initial begin
    tx_o = 1'b1;
    rx_byte_o = 8'h00;
    rx_stb_o = 1'b0;
  end

  // Drives one level for whole bit times at the fastest legal rate.
  task automatic hold(input logic v, input int bits);
    tx_o = v;
    repeat (bits * BIT_CYC) @(posedge clk_i);
    #1;
  endtask

  // Sends the dominant break and its recessive delimiter.
  task automatic send_break();
    hold(1'b0, 13);
    hold(1'b1, 1);
  endtask

  // Sends one character LSB first; bad flips parity, stp sets stop.
  task automatic send_char(input logic [7:0] c, input logic [1:0] par,
                           input logic bad, input logic stp);
    hold(1'b0, 1);
    for (int i = 0; i < 8; i++)
      hold(c[i], 1);
    if (par != `LNUF_PAR_NONE)
      hold(^c ^ (par == `LNUF_PAR_ODD) ^ bad, 1);
    hold(stp, 1);
    if (!stp)
      hold(1'b1, 1);
  endtask

  // Samples each bit mid-cell; a low stop after zero data is a break,
  // reported as its length in bit times.
  initial begin
    forever begin
      @(posedge clk_i);
      if (line_i === 1'b0) begin
        repeat (BIT_CYC / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYC) @(posedge clk_i);
          b[i] = line_i;
        end
        repeat (BIT_CYC) @(posedge clk_i);
        if (b == 8'h00 && line_i === 1'b0) begin
          n = 19 * BIT_CYC / 2;
          while (line_i !== 1'b1) begin
            @(posedge clk_i);
            n++;
          end
          b = 8'((n + BIT_CYC / 2) / BIT_CYC);
        end
        rx_byte_o <= b;
        rx_stb_o <= 1'b1;
        @(posedge clk_i);
        rx_stb_o <= 1'b0;
        while (line_i !== 1'b1) @(posedge clk_i);
      end
    end
  end
endmodule

/* lnuf_pkg.sv */
// Types shared by the LIN/UART frame handler.
// Assumes the constants header sits in the same folder.
package lnuf_pkg;
  // Transmit sequencer phases.
  typedef enum logic [2:0] {T_IDLE, T_BRK, T_SYNC, T_PID, T_DATA,
                            T_CSUM} lnuf_tx_e;
  // Receive header and response phases.
  typedef enum logic [1:0] {R_BRK, R_SYNC, R_PID, R_DATA} lnuf_rx_e;
  // Whole state of the frame handler.
  typedef struct packed {
    logic line; lnuf_tx_e tph; logic [10:0] tsh; logic [3:0] tbits;
    logic [9:0] tcnt; logic [3:0] tidx; logic [7:0] tsum;
    logic [5:0] hid; logic [3:0] len;
    logic rxp; logic rbusy; logic [9:0] rcnt; logic [3:0] rbit;
    logic [10:0] rsh; logic [9:0] blen; lnuf_rx_e rst; logic [2:0] edges;
    logic [12:0] meas; logic [7:0] rsum; logic [3:0] ridx;
    logic [63:0] rbuf; logic tx_pend; logic rx_pend; logic fr_on;
    logic [9:0] fcyc; logic [8:0] fbits;
    logic [7:0] rdata; logic rvalid; logic idok; logic [5:0] id;
    logic idsp; logic iddg; logic [63:0] resp; logic rok; logic tok;
    logic cerr; logic perr; logic ferr; logic ovr; logic tmo;
  } lnuf_top_s;
endpackage

/* lnuf_regs.svh */
// Named constants of the LIN/UART frame handler.
// Assumes a 10 MHz core clock; included by the design and the bench.
`ifndef LNUF_REGS_SVH
`define LNUF_REGS_SVH
// Core clock period in ns.
`define LNUF_CLK_NS 100
// Shortest bit time on the bus in ns, the 20 kbit/s ceiling.
`define LNUF_BIT_NS 50000
// Cycles per bit, rounded up so the rate never exceeds the ceiling.
`define LNUF_BIT_CYC 10'((`LNUF_BIT_NS + `LNUF_CLK_NS - 1) / `LNUF_CLK_NS)
// Break of 13 dominant bits plus one recessive delimiter bit.
`define LNUF_BRK_LEN 4'hE
// Sync character value.
`define LNUF_SYNC 8'h55
// Character lengths in bits without and with parity.
`define LNUF_CHR_NP 4'hA
`define LNUF_CHR_P 4'hB
// Parity selections.
`define LNUF_PAR_NONE 2'h0
`define LNUF_PAR_EVEN 2'h1
`define LNUF_PAR_ODD 2'h2
// First special identifier and the two diagnostic identifiers.
`define LNUF_ID_SPEC 6'h3C
`define LNUF_ID_DIAG0 6'h3C
`define LNUF_ID_DIAG1 6'h3D
// Falling edge index of the sync field that ends an 8-bit span.
`define LNUF_SYNC_FALLS 3'h4
// Nominal frame length terms, in bits, and the 1.4 tolerance.
`define LNUF_HDR_BITS 34
`define LNUF_BYTE_BITS 10
`define LNUF_TOL_NUM 14
`define LNUF_TOL_DEN 10
`endif
